// *** rtl/pllsyn_pkg.sv ***
// constants shared by the synthesizer divider control block
// assumes a single 200 MHz system clock and byte-addressed register access
package pllsyn_pkg;
  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam int          ADDR_W    = 5;
  localparam logic [4:0]  OFF_STAT  = 5'h00;
  localparam logic [4:0]  OFF_MASK  = 5'h04;
  localparam logic [4:0]  OFF_REF   = 5'h08;
  localparam logic [4:0]  OFF_DIV   = 5'h0C;
  // ----------------------------------------
  // status and mask layout
  // ----------------------------------------
  localparam int          ST_W      = 3;
  localparam int          ST_REF    = 0;
  localparam int          ST_DIV    = 1;
  localparam int          ST_LOSS   = 2;
  localparam logic [2:0]  RST_STAT  = 3'h0;
  localparam logic [2:0]  RST_MASK  = 3'h0;
  // ----------------------------------------
  // serial word layout, last bit shifted sits at bit 0
  // ----------------------------------------
  localparam int          CTL_BIT   = 0;
  localparam int          SEL_BIT   = 1;
  localparam int          REF_LSB   = 2;
  localparam int          SWAL_LSB  = 1;
  // ----------------------------------------
  // latch values after reset
  // ----------------------------------------
  localparam int          RST_REF   = 8;
  localparam int          RST_MAIN  = 16;
  localparam int          RST_SWAL  = 0;
  localparam logic        RST_SEL   = 1'b0;
  // ----------------------------------------
  // prescaler small modulus per select bit
  // ----------------------------------------
  localparam int          PSC_SMALL = 64;
  localparam int          PSC_LARGE = 128;
  // pin order: vco, ref, polarity, strobe, data, serial clock
  localparam logic [5:0]  PIN_RST   = 6'h0C;
endpackage : pllsyn_pkg

// *** rtl/pllsyn_sync.sv ***
// three-stage input synchroniser with agreement filter
// assumes din is asynchronous to clk
`timescale 1ns/100ps
module pllsyn_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      level,
  output logic      rise
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic nxt_lvl;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a change counts only once stages two and three agree
  assign nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      lvl_ff <= RST_VAL;
    end else begin
      lvl_ff <= nxt_lvl;
    end
  end

  assign level = lvl_ff;
  assign rise  = nxt_lvl & ~lvl_ff;
endmodule : pllsyn_sync

// *** rtl/pllsyn_cnt.sv ***
// loadable down counter used by every divider stage
// assumes load and dec are one-cycle strobes on clk
`timescale 1ns/100ps
module pllsyn_cnt #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         dec,
  output logic      [W-1:0] cnt
);
  logic [W-1:0] cnt_ff;

  // load beats decrement so a terminal count restarts cleanly
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (dec) begin
      cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign cnt = cnt_ff;
endmodule : pllsyn_cnt

// *** rtl/pllsyn_top.sv ***
// serial-programmed pulse-swallow synthesizer divider control
// assumes all link pins are asynchronous and sampled on clk;
// pump and switch pins are resolved outside from their enables
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module pllsyn_top #(
  parameter int REF_W  = 14,
  parameter int SWAL_W = 7,
  parameter int MAIN_W = 11,
  parameter int PSC_W  = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        serial_clk_in,
  input  wire logic        serial_data_in,
  input  wire logic        latch_transfer_strobe,
  input  wire logic        phase_polarity_sel,
  input  wire logic        ref_crystal_input,
  input  wire logic        vco_input,
  output logic             ref_crystal_output,
  output logic             main_pump_out,
  output logic             main_pump_oe_n,
  output logic             fast_lock_switch_out,
  output logic             fast_lock_switch_oe_n,
  output logic             ext_pump_up_drive,
  output logic             ext_pump_ref_drive,
  output logic             lock_indicator,
  output logic             compare_monitor_out
);
  localparam int SR_W = MAIN_W + SWAL_W + 1;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] pin_lvl;
  logic [5:0] pin_rise;

  assign pin_raw = {vco_input, ref_crystal_input, phase_polarity_sel,
                    latch_transfer_strobe, serial_data_in, serial_clk_in};

  // strobe and polarity reset high, as an open pin reads
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pin
      pllsyn_sync #(
        .RST_VAL (pllsyn_pkg::PIN_RST[gi])
      ) u_sync (
        .clk   (clk),
        .rst   (rst),
        .din   (pin_raw[gi]),
        .level (pin_lvl[gi]),
        .rise  (pin_rise[gi])
      );
    end
  endgenerate

  logic sclk_rise;
  logic data_lvl;
  logic strb_lvl;
  logic strb_rise;
  logic pol_lvl;
  logic ref_lvl;
  logic ref_rise;
  logic vco_rise;

  assign sclk_rise = pin_rise[0];
  assign data_lvl  = pin_lvl[1];
  assign strb_lvl  = pin_lvl[2];
  assign strb_rise = pin_rise[2];
  assign pol_lvl   = pin_lvl[3];
  assign ref_lvl   = pin_lvl[4];
  assign ref_rise  = pin_rise[4];
  assign vco_rise  = pin_rise[5];

  // ----------------------------------------
  // shift register and latches
  // ----------------------------------------
  logic [SR_W-1:0]   sr_ff;
  logic [REF_W-1:0]  r_lat_ff;
  logic              sel_lat_ff;
  logic [MAIN_W-1:0] n_lat_ff;
  logic [SWAL_W-1:0] a_lat_ff;
  logic [REF_W-1:0]  sr_r;
  logic [MAIN_W-1:0] sr_n;
  logic [SWAL_W-1:0] sr_a;
  logic              sr_ctl;

  assign sr_ctl = sr_ff[pllsyn_pkg::CTL_BIT];
  assign sr_r   = sr_ff[pllsyn_pkg::REF_LSB +: REF_W];
  assign sr_n   = sr_ff[SR_W-1 -: MAIN_W];
  assign sr_a   = sr_ff[pllsyn_pkg::SWAL_LSB +: SWAL_W];

  always_ff @(posedge clk) begin
    if (rst) begin
      sr_ff <= '0;
    end else if (sclk_rise) begin
      sr_ff <= {sr_ff[SR_W-2:0], data_lvl};
    end
  end

  // level-sensitive copy; shifting alone never disturbs the counters
  always_ff @(posedge clk) begin
    if (rst) begin
      r_lat_ff   <= REF_W'(pllsyn_pkg::RST_REF);
      sel_lat_ff <= pllsyn_pkg::RST_SEL;
      n_lat_ff   <= MAIN_W'(pllsyn_pkg::RST_MAIN);
      a_lat_ff   <= SWAL_W'(pllsyn_pkg::RST_SWAL);
    end else if (strb_lvl) begin
      if (sr_ctl) begin
        r_lat_ff   <= sr_r;
        sel_lat_ff <= sr_ff[pllsyn_pkg::SEL_BIT];
      end else begin
        n_lat_ff   <= sr_n;
        a_lat_ff   <= sr_a;
      end
    end
  end

  // ----------------------------------------
  // reference divider
  // ----------------------------------------
  logic [REF_W-1:0] ref_cnt;
  logic             ref_tc;
  logic             ref_pulse_ff;

  assign ref_tc = ref_cnt <= REF_W'(1);

  pllsyn_cnt #(
    .W (REF_W)
  ) u_ref_cnt (
    .clk      (clk),
    .rst      (rst),
    .load     (ref_rise & ref_tc),
    .load_val (r_lat_ff),
    .dec      (ref_rise),
    .cnt      (ref_cnt)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_pulse_ff <= 1'b0;
    end else begin
      ref_pulse_ff <= ref_rise & ref_tc;
    end
  end

  // ----------------------------------------
  // prescaler, swallow and main counters
  // ----------------------------------------
  logic [PSC_W-1:0]  psc_cnt;
  logic [SWAL_W-1:0] swal_cnt;
  logic [MAIN_W-1:0] main_cnt;
  logic [PSC_W-1:0]  p_mod;
  logic [PSC_W-1:0]  psc_mod;
  logic [SWAL_W-1:0] swal_nx;
  logic              pend;
  logic              main_done;
  logic              vco_pulse_ff;

  // select 0 gives 128/129, 1 gives 64/65
  assign p_mod = sel_lat_ff ? PSC_W'(pllsyn_pkg::PSC_SMALL)
                            : PSC_W'(pllsyn_pkg::PSC_LARGE);
  assign pend      = vco_rise & (psc_cnt <= PSC_W'(1));
  assign main_done = pend & (main_cnt <= MAIN_W'(1));
  assign swal_nx   = main_done ? a_lat_ff :
                     (swal_cnt == '0) ? '0 : swal_cnt - SWAL_W'(1);
  // large modulus while swallow remains
  assign psc_mod   = (swal_nx != '0) ? p_mod + PSC_W'(1) : p_mod;

  pllsyn_cnt #(
    .W (PSC_W)
  ) u_psc_cnt (
    .clk      (clk),
    .rst      (rst),
    .load     (pend),
    .load_val (psc_mod),
    .dec      (vco_rise),
    .cnt      (psc_cnt)
  );

  pllsyn_cnt #(
    .W (SWAL_W)
  ) u_swal_cnt (
    .clk      (clk),
    .rst      (rst),
    .load     (main_done),
    .load_val (a_lat_ff),
    .dec      (pend & (swal_cnt != '0)),
    .cnt      (swal_cnt)
  );

  pllsyn_cnt #(
    .W (MAIN_W)
  ) u_main_cnt (
    .clk      (clk),
    .rst      (rst),
    .load     (main_done),
    .load_val (n_lat_ff),
    .dec      (pend),
    .cnt      (main_cnt)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      vco_pulse_ff <= 1'b0;
    end else begin
      vco_pulse_ff <= main_done;
    end
  end

  // ----------------------------------------
  // phase/frequency comparator
  // ----------------------------------------
  logic up_ff;
  logic dn_ff;
  logic up_set;
  logic dn_set;
  logic lead;
  logic lag;

  assign up_set = up_ff | ref_pulse_ff;
  assign dn_set = dn_ff | vco_pulse_ff;

  // both edges seen: clear together, no dead band memory
  always_ff @(posedge clk) begin
    if (rst) begin
      up_ff <= 1'b0;
      dn_ff <= 1'b0;
    end else begin
      up_ff <= up_set & ~dn_set;
      dn_ff <= dn_set & ~up_set;
    end
  end

  assign lead = pol_lvl ? up_ff : dn_ff;
  assign lag  = pol_lvl ? dn_ff : up_ff;

  // ----------------------------------------
  // pump, switch and monitor outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      main_pump_out         <= 1'b0;
      main_pump_oe_n        <= 1'b1;
      fast_lock_switch_out  <= 1'b0;
      fast_lock_switch_oe_n <= 1'b1;
      ext_pump_up_drive     <= 1'b1;
      ext_pump_ref_drive    <= 1'b0;
      lock_indicator        <= 1'b1;
      compare_monitor_out   <= 1'b0;
      ref_crystal_output    <= 1'b1;
    end else begin
      main_pump_out         <= lead;
      main_pump_oe_n        <= ~(lead | lag);
      fast_lock_switch_out  <= lead;
      fast_lock_switch_oe_n <= ~(strb_lvl & (lead | lag));
      ext_pump_up_drive     <= ~lead;
      ext_pump_ref_drive    <= lag;
      lock_indicator        <= ~(up_ff | dn_ff);
      compare_monitor_out   <= pol_lvl ? ref_pulse_ff : vco_pulse_ff;
      ref_crystal_output    <= ~ref_lvl;
    end
  end

  // ----------------------------------------
  // register slave and interrupt
  // ----------------------------------------
  logic [2:0] stat_ff;
  logic [2:0] mask_ff;
  logic [2:0] stat_ev;
  logic [2:0] stat_clr;
  logic       lock_ff;
  logic       wr_acc;
  logic [31:0] rd_mux;

  // access answered one cycle after it is seen
  assign wr_acc = avs_write & ~avs_waitrequest;

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      pllsyn_pkg::OFF_STAT: rd_mux = {29'h0, stat_ff};
      pllsyn_pkg::OFF_MASK: rd_mux = {29'h0, mask_ff};
      pllsyn_pkg::OFF_REF:  rd_mux = 32'({sel_lat_ff, r_lat_ff});
      pllsyn_pkg::OFF_DIV:  rd_mux = 32'({n_lat_ff, a_lat_ff});
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_ff <= pllsyn_pkg::RST_MASK;
    end else if (wr_acc && avs_address == pllsyn_pkg::OFF_MASK) begin
      mask_ff <= avs_writedata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_ff <= 1'b1;
    end else begin
      lock_ff <= ~(up_ff | dn_ff);
    end
  end

  assign stat_ev[pllsyn_pkg::ST_REF]  = strb_rise & sr_ctl;
  assign stat_ev[pllsyn_pkg::ST_DIV]  = strb_rise & ~sr_ctl;
  assign stat_ev[pllsyn_pkg::ST_LOSS] = lock_ff & (up_ff | dn_ff);
  assign stat_clr = (wr_acc && avs_address == pllsyn_pkg::OFF_STAT)
                    ? avs_writedata[2:0] : 3'h0;

  // a new event beats a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_ff <= pllsyn_pkg::RST_STAT;
    end else begin
      stat_ff <= (stat_ff & ~stat_clr) | stat_ev;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_ff & mask_ff);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_psc_end;
    vco_rise ##0 (psc_cnt <= PSC_W'(1));
  endsequence

  sequence s_cycle_end;
    s_psc_end ##0 (main_cnt <= MAIN_W'(1));
  endsequence

  a_pullup_default: assert property ($fell(rst) |-> strb_lvl && pol_lvl)
    else $error("open strobe or polarity not read high");
  a_shift_bit: assert property (sclk_rise |=> sr_ff[0] == $past(data_lvl))
    else $error("serial bit not shifted in");
  a_latch_copy: assert property (strb_lvl && sr_ctl |=> r_lat_ff == $past(sr_r))
    else $error("reference latch not loaded");
  a_latch_hold: assert property (!strb_lvl |=> $stable(n_lat_ff) && $stable(r_lat_ff))
    else $error("latch changed without strobe");
  a_ref_reload: assert property (ref_pulse_ff |-> ref_cnt == $past(r_lat_ff))
    else $error("reference counter not reloaded");
  a_psc_modulus: assert property (s_psc_end |=> psc_cnt == $past(psc_mod))
    else $error("prescaler loaded with wrong modulus");
  a_div_reload: assert property (s_cycle_end |=> swal_cnt == $past(a_lat_ff)
                                 ##1 vco_pulse_ff == 1'b0)
    else $error("divider cycle did not restart");
  a_switch_hiz: assert property (!strb_lvl |=> fast_lock_switch_oe_n)
    else $error("switch driven with strobe low");
  a_pol_reverse: assert property (up_ff && !dn_ff && !pol_lvl |=> ext_pump_ref_drive)
    else $error("reversed polarity not applied");
  a_monitor_sel: assert property (ref_pulse_ff && pol_lvl |=> compare_monitor_out)
    else $error("monitor missed reference pulse");
  a_pump_active: assert property ((up_ff || dn_ff) && !strb_lvl |=> !main_pump_oe_n)
    else $error("main pump gated");
endmodule : pllsyn_top

// *** dv/pllsyn_host.sv ***
// host model driving the three-wire programming port
// assumes every pin move is timed in whole cycles of clk
`timescale 1ns/100ps
module pllsyn_host (
  input  wire logic clk,
  output logic      serial_clk_in,
  output logic      serial_data_in,
  output logic      latch_transfer_strobe
);
  initial begin
    serial_clk_in         = 1'h0;
    serial_data_in        = 1'h0;
    latch_transfer_strobe = 1'h0;
  end
  // ----------
  // word shift and load
  // ----------
  // 160 ns bit period as 32 clk; pins move by nba on clk edges,
  // each link level stands far longer than the input filter needs
  task automatic send(input logic [18:0] word, input int len);
    @(posedge clk);
    for (int i = len - 1; i >= 0; i--) begin
      serial_data_in <= word[i];
      repeat (16) @(posedge clk);
      serial_clk_in <= 1'h1;
      repeat (8) @(posedge clk);
      serial_data_in <= ~word[i];
      repeat (8) @(posedge clk);
      serial_clk_in <= 1'h0;
    end
  endtask : send
  // gap in clk cycles stretches the wait before the strobe, a slow host
  task automatic load(input int gap);
    repeat (8 + gap) @(posedge clk);
    latch_transfer_strobe <= 1'h1;
    repeat (40) @(posedge clk);
    latch_transfer_strobe <= 1'h0;
    repeat (20) @(posedge clk);
  endtask : load
  task automatic hold_strobe(input logic lvl);
    @(posedge clk);
    latch_transfer_strobe <= lvl;
  endtask : hold_strobe
endmodule : pllsyn_host

// *** dv/tb_top.sv ***
// self-checking bench for the synthesizer divider control block
// assumes the host model owns the serial pins, all else is driven here
`timescale 1ns/100ps
module tb_top;
  typedef struct {
    logic [18:0] w;
    int          len;
    logic [4:0]  off;
    logic [31:0] exp;
    logic [2:0]  st;
  } pllsyn_row_t;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        serial_clk_in, serial_data_in, latch_transfer_strobe, phase_polarity_sel;
  logic        ref_crystal_input, vco_input, ref_crystal_output, main_pump_out, main_pump_oe_n;
  logic        fast_lock_switch_out, fast_lock_switch_oe_n, ext_pump_up_drive, ext_pump_ref_drive;
  logic        lock_indicator, compare_monitor_out, ref_en, vco_en;
  int          errors = 0;
  int          cmp_count = 0;
  int          ph = 0;
  int          rises = 0;
  int          n0;
  int          mon_q[$];
  pllsyn_row_t rows [5] = '{'{19'h00021, 16, 5'h08, 32'h8, 3'h1},
                            '{19'h0FFFF, 16, 5'h08, 32'h7FFF, 3'h1},
                            '{19'h01000, 19, 5'h0C, 32'h800, 3'h2},
                            '{19'h7FFFE, 19, 5'h0C, 32'h3FFFF, 3'h2},
                            '{19'h064C6, 19, 5'h0C, 32'h3263, 3'h2}};

  pllsyn_top DUT (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .irq, .serial_clk_in, .serial_data_in, .latch_transfer_strobe,
    .phase_polarity_sel, .ref_crystal_input, .vco_input, .ref_crystal_output, .main_pump_out,
    .main_pump_oe_n, .fast_lock_switch_out, .fast_lock_switch_oe_n, .ext_pump_up_drive,
    .ext_pump_ref_drive, .lock_indicator, .compare_monitor_out);
  pllsyn_host u_host (.clk, .serial_clk_in, .serial_data_in, .latch_transfer_strobe);

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // ----------
  // oscillator inputs and monitor log
  // ----------
  // each level held 3 clk so the input filter never drops an edge
  always @(posedge clk) begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (ph == 2) begin
      if (ref_en) ref_crystal_input <= ~ref_crystal_input;
      if (vco_en) vco_input <= ~vco_input;
      if ((ref_en && !ref_crystal_input) || (vco_en && !vco_input)) rises <= rises + 1;
    end
    if (compare_monitor_out === 1'h1) mon_q.push_back(rises);
  end
  // ----------
  // shared tasks
  // ----------
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (n >= 20) begin
      errors++;
      summarize();
    end
  endtask : bus
  // longest wait is three cycles of the 128/129 divider
  task automatic wait_mon(input int need);
    int n;
    n = 0;
    while (mon_q.size() < need && n < 45000) begin
      @(posedge clk);
      n++;
    end
    if (mon_q.size() < need) begin
      errors++;
      summarize();
    end
  endtask : wait_mon
  // ----------
  // main sequence
  // ----------
  initial begin
    rst = 1'h1;
    avs_address = 5'h00;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    phase_polarity_sel = 1'h1;
    ref_crystal_input = 1'h0;
    vco_input = 1'h0;
    ref_en = 1'h0;
    vco_en = 1'h0;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    bus(1'h1, 5'h04, 32'h7);
    for (int i = 0; i < 5; i++) begin
      u_host.send(rows[i].w, rows[i].len);
      u_host.load(i * 20);
      bus(1'h0, 5'h00, 32'h0);
      chk(rd, {29'h0, rows[i].st});
      chk(irq, 1'h1);
      bus(1'h1, 5'h00, {29'h0, rows[i].st});
      bus(1'h0, rows[i].off, 32'h0);
      chk(rd, rows[i].exp);
      chk(irq, 1'h0);
      $display("table row %0d done", i);
    end
    bus(1'h1, 5'h10, 32'h5);
    bus(1'h0, 5'h10, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 5'h04, 32'h0);
    chk(rd, 32'h7);
    $display("unmapped test done");
    // old ratios must survive shifting and a read-only write
    bus(1'h1, 5'h08, 32'h0);
    u_host.send(19'h00021, 16);
    bus(1'h0, 5'h08, 32'h0);
    chk(rd, 32'h7FFF);
    bus(1'h0, 5'h00, 32'h0);
    chk(rd, 32'h0);
    u_host.load(0);
    bus(1'h0, 5'h08, 32'h0);
    chk(rd, 32'h8);
    bus(1'h1, 5'h00, 32'h7);
    $display("hold test done");
    @(posedge clk);
    ref_en <= 1'h1;
    n0 = mon_q.size();
    wait_mon(n0 + 3);
    chk(mon_q[$] - mon_q[$ - 1], 8);
    chk({ext_pump_up_drive, ext_pump_ref_drive, main_pump_oe_n, main_pump_out, fast_lock_switch_oe_n,
         lock_indicator}, 6'h06);
    u_host.hold_strobe(1'h1);
    repeat (8) @(posedge clk);
    chk({fast_lock_switch_oe_n, fast_lock_switch_out, main_pump_oe_n}, 3'h2);
    u_host.hold_strobe(1'h0);
    @(posedge clk);
    phase_polarity_sel <= 1'h0;
    repeat (6) @(posedge clk);
    n0 = mon_q.size();
    repeat (150) @(posedge clk);
    chk({ext_pump_up_drive, ext_pump_ref_drive, main_pump_out, main_pump_oe_n}, 4'hC);
    chk(mon_q.size(), n0);
    ref_en <= 1'h0;
    // strobe rise with a reference word shifted, and the lock loss, both latched
    bus(1'h0, 5'h00, 32'h0);
    chk(rd, 32'h5);
    chk(irq, 1'h1);
    bus(1'h1, 5'h00, 32'h7);
    $display("comparator test done");
    for (int s = 1; s >= 0; s--) begin
      u_host.send({3'h0, 14'h8, s[0], 1'h1}, 16);
      u_host.load(0);
      u_host.send(19'h01006, 19);
      u_host.load(0);
      @(posedge clk);
      vco_en <= 1'h1;
      n0 = mon_q.size();
      wait_mon(n0 + 3);
      chk(mon_q[$] - mon_q[$ - 1], (s ? 64 : 128) * 16 + 3);
      vco_en <= 1'h0;
      $display("prescaler mode %0d test done", s);
    end
    // reference input idle long enough for the inverted output to settle
    chk(ref_crystal_output, {~ref_crystal_input});
    // second reset in mid-run returns pins and registers to idle
    @(posedge clk);
    rst <= 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk({lock_indicator, ext_pump_up_drive, ext_pump_ref_drive, main_pump_oe_n, fast_lock_switch_oe_n,
         compare_monitor_out, irq, ref_crystal_output}, 8'hD9);
    bus(1'h0, 5'h00, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 5'h04, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    summarize();
  end
endmodule : tb_top
